/* File: hdl/rfid_irq_status.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module rfid_irq_status
    import rfid_irq_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      sys_rst_i,
    // Enable pin, asynchronous
    input  wire logic      enable_i,
    // Register port
    input  wire reg_req_t  req_i,
    output logic [7:0]     rdata_o,
    // Datapath events, same clock
    input  wire rf_event_t ev_i,
    // Host interrupt and controls
    output logic           irq_o,
    output logic           decoder_enable_o,
    output reg_sel_t       regulator_o
);
    state_t q;
    state_t next_q;

    // Headroom decode for automatic regulation
    function automatic logic [8:0] headroom(input logic [1:0] code);
        if (code == VS_250) begin
            return HEAD_250;
        end else if (code == VS_350) begin
            return HEAD_350;
        end else begin
            return HEAD_400;
        end
    endfunction

    // Register read or write decode
    function automatic logic hit(input logic s, input logic [7:0] a,
                                 input logic [7:0] o);
        return s && (a == o);
    endfunction

    logic tx_start;
    logic tx_end;
    logic rx_end;
    logic fifo_ev;
    logic crc_ev;
    logic par_ev;
    logic frm_ev;
    logic col_ev;
    logic nrsp_ev;
    logic pos_ev;
    logic [3:0] col_limit;
    logic [7:0] set_bits;
    logic [5:0] ev6;
    logic enabled_hit;
    logic rd_stat;
    logic rd_mask;
    logic rd_col;

    // Event detection from datapath levels and pulses
    always_comb begin
        tx_start = ev_i.tx_active && !q.tx_d;
        tx_end   = !ev_i.tx_active && q.tx_d;
        rx_end   = !ev_i.rx_active && q.rx_d;
        fifo_ev  = (ev_i.rx_active && ev_i.fifo_count > FIFO_RX_HIGH)
                 || (ev_i.tx_active && ev_i.fifo_count < FIFO_TX_LOW);
        crc_ev   = ev_i.crc_fail && !q.proto[P_NO_RX_CRC];
        par_ev   = ev_i.parity_fail && !q.proto[P_NOT_TYPE_A];
        frm_ev   = ev_i.framing_fail || ev_i.eof_fail;
        col_limit = q.proto[P_COLLISION_POS_LOW_MSB_SEL] ? COL_EDGES_7 : COL_EDGES_6;
        col_ev   = ev_i.bit_end && !q.proto[P_NOT_TYPE_A]
                 && (ev_i.bit_edges > col_limit);
        nrsp_ev  = ev_i.noresp_timeout;
        // Errors only land outside transmit, decoder is off then
        if (ev_i.tx_active) begin
            crc_ev  = 1'b0;
            par_ev  = 1'b0;
            frm_ev  = 1'b0;
            col_ev  = 1'b0;
            nrsp_ev = 1'b0;
        end
        pos_ev = col_ev || (q.proto[P_NOT_TYPE_A]
                 && (frm_ev || ev_i.parity_fail || crc_ev));
        set_bits = '0;
        set_bits[B_TX]   = tx_start;
        set_bits[B_SRX]  = ev_i.sof && ev_i.rx_active && !ev_i.tx_active;
        set_bits[B_FIFO] = fifo_ev;
        set_bits[B_CRC]  = crc_ev;
        set_bits[B_PAR]  = par_ev;
        set_bits[B_FRM]  = frm_ev;
        set_bits[B_COL]  = col_ev;
        set_bits[B_NRSP] = nrsp_ev;
        ev6 = set_bits[B_FIFO:B_NRSP];
        enabled_hit = |(ev6 & q.mask);
        rd_stat = hit(req_i.rd, req_i.addr, OFS_STATUS);
        rd_mask = hit(req_i.rd, req_i.addr, OFS_MASK);
        rd_col  = hit(req_i.rd, req_i.addr, OFS_COLLO);
    end

    // Next state: register file, flags and interrupt
    always_comb begin
        next_q = q;
        next_q.en_meta = enable_i;
        next_q.en_sync = q.en_meta;
        next_q.tx_d = ev_i.tx_active;
        next_q.rx_d = ev_i.rx_active;
        next_q.dec_en = !ev_i.tx_active;
        // Read data, unmapped offsets read zero
        next_q.rdata = '0;
        if (req_i.rd) begin
            unique case (req_i.addr)
                OFS_PROTO:  next_q.rdata = q.proto;
                OFS_REGCTL: next_q.rdata = q.regctl;
                OFS_STATUS: next_q.rdata = q.status;
                OFS_MASK:   next_q.rdata = {q.colpos[9:8], q.mask};
                OFS_COLLO:  next_q.rdata = q.colpos[7:0];
                default:    next_q.rdata = '0;
            endcase
        end
        // Read-clear first, so a same-cycle event still sets
        if (rd_stat) begin
            next_q.status = '0;
            next_q.irq = 1'b0;
        end
        if (rd_mask) begin
            next_q.colpos[9:8] = '0;
        end
        if (rd_col) begin
            next_q.colpos[7:0] = '0;
        end
        // Writes
        if (hit(req_i.wr, req_i.addr, OFS_PROTO)) begin
            next_q.proto = req_i.wdata;
            next_q.status = '0;
        end
        if (hit(req_i.wr, req_i.addr, OFS_REGCTL)) begin
            next_q.regctl = req_i.wdata & REGCTL_WMASK;
        end
        if (hit(req_i.wr, req_i.addr, OFS_MASK)) begin
            next_q.mask = req_i.wdata[5:0];
        end
        // Event setting wins over any clear
        next_q.status = next_q.status | set_bits;
        if (pos_ev) begin
            next_q.colpos = ev_i.bit_pos;
        end
        // Phase ends and enabled events raise the line
        if (tx_end || rx_end || enabled_hit) begin
            next_q.irq = 1'b1;
        end
        // Regulator decode, bit 2 ignored in auto mode
        next_q.regsel.auto_mode = q.regctl[R_AUTO];
        next_q.regsel.manual_set = q.regctl[2:0];
        next_q.regsel.headroom_mv = headroom(q.regctl[1:0]);
        // Enable pin low holds everything in reset
        if (!q.en_sync) begin
            next_q = '0;
            next_q.en_meta = enable_i;
            next_q.en_sync = q.en_meta;
            next_q.status = RST_STATUS;
            next_q.mask = RST_MASK[5:0];
            next_q.regctl = RST_REGCTL;
            next_q.proto = RST_PROTO;
            next_q.dec_en = 1'b1;
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.status <= RST_STATUS;
            q.mask <= RST_MASK[5:0];
            q.regctl <= RST_REGCTL;
            q.proto <= RST_PROTO;
            q.dec_en <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flops
    assign rdata_o = q.rdata;
    assign irq_o = q.irq;
    assign decoder_enable_o = q.dec_en;
    assign regulator_o = q.regsel;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !q.en_sync);

    // Helper: status read in previous cycle with no phase end or enabled event
    logic prev_rd;
    logic [7:0] prev_set;
    always_ff @(posedge clk_i) begin
        prev_rd <= rd_stat && !tx_end && !rx_end && !enabled_hit;
        prev_set <= set_bits;
    end

    status_read_clr_a: assert property (
        rd_stat |=> (q.status == $past(set_bits) && (prev_rd -> !q.irq)))
        else $error("status not cleared by read");
    proto_wr_clr_a: assert property (
        hit(req_i.wr, req_i.addr, OFS_PROTO) |=> q.status == prev_set)
        else $error("status not cleared by protocol write");
    tx_dec_off_a: assert property (
        ev_i.tx_active |=> !decoder_enable_o)
        else $error("decoder active during transmit");
    // Outside transmit the decoder must come back one cycle later
    dec_back_a: assert property (
        !ev_i.tx_active |=> decoder_enable_o)
        else $error("decoder still off after transmit");
    // Error flags frozen while transmitting, barring explicit clears
    tx_errs_hold_a: assert property (
        (ev_i.tx_active && !rd_stat && !hit(req_i.wr, req_i.addr, OFS_PROTO))
        |=> q.status[B_CRC:B_NRSP] == $past(q.status[B_CRC:B_NRSP]))
        else $error("error flag changed during transmit");
    rx_no_irq_a: assert property (
        (ev_i.sof && ev_i.rx_active && !q.irq && !rd_stat
         && !tx_end && !rx_end && !enabled_hit) |=> !irq_o)
        else $error("receive start raised interrupt early");
    phase_end_irq_a: assert property (
        ($fell(ev_i.tx_active) || $fell(ev_i.rx_active)) |=> irq_o)
        else $error("no interrupt at phase end");
    tx_flag_set_a: assert property (
        $rose(ev_i.tx_active) |=> q.status[B_TX])
        else $error("transmit flag not set at start");
    fifo_rx_a: assert property (
        (ev_i.rx_active && ev_i.fifo_count > FIFO_RX_HIGH) |=> q.status[B_FIFO])
        else $error("FIFO high not flagged");
    crc_gate_a: assert property (
        (ev_i.crc_fail && q.proto[P_NO_RX_CRC] && !rd_stat
         && !hit(req_i.wr, req_i.addr, OFS_PROTO)) |=>
            q.status[B_CRC] == $past(q.status[B_CRC]))
        else $error("CRC flagged while checking off");
    col_edges_a: assert property (
        (ev_i.bit_end && !ev_i.tx_active && !q.proto[P_NOT_TYPE_A]
         && ev_i.bit_edges > COL_EDGES_7) |=> q.status[B_COL] ##1 1)
        else $error("collision not flagged");
    mask_gate_a: assert property (
        (!q.irq && !tx_end && !rx_end && set_bits[B_FIFO:B_NRSP] != '0
         && (set_bits[B_FIFO:B_NRSP] & q.mask) == '0) |=> !irq_o)
        else $error("masked event raised interrupt");
    colpos_read_a: assert property (
        (rd_col && !pos_ev) |=> q.colpos[7:0] == '0)
        else $error("collision position not read-cleared");
    headroom_a: assert property (
        q.regctl[1:0] == VS_250 |=> regulator_o.headroom_mv == HEAD_250)
        else $error("wrong headroom decode");

    // Low fill during transmit must flag the FIFO bit
    fifo_tx_a: assert property (
        (ev_i.tx_active && ev_i.fifo_count < FIFO_TX_LOW) |=> q.status[B_FIFO])
        else $error("FIFO low not flagged");
    // Parity fault in Type A outside transmit
    parity_set_a: assert property (
        (ev_i.parity_fail && !ev_i.tx_active && !q.proto[P_NOT_TYPE_A])
        |=> q.status[B_PAR])
        else $error("parity error not flagged");
    // Byte framing and end-of-frame faults share one flag
    framing_set_a: assert property (
        ((ev_i.framing_fail || ev_i.eof_fail) && !ev_i.tx_active)
        |=> q.status[B_FRM])
        else $error("framing error not flagged");
    // Wait-time expiry outside transmit
    noresp_set_a: assert property (
        (ev_i.noresp_timeout && !ev_i.tx_active) |=> q.status[B_NRSP])
        else $error("no-response not flagged");
    // Enable bits read back in the low six bits of the mask offset
    mask_read_a: assert property (
        rd_mask |=> rdata_o[5:0] == $past(q.mask))
        else $error("mask read back wrong");
    // Upper position bits drop after a mask read
    colhi_read_a: assert property (
        (rd_mask && !pos_ev) |=> q.colpos[9:8] == '0)
        else $error("upper position bits not read-cleared");
    // Captured position is the bit where the fault happened
    pos_capture_a: assert property (
        pos_ev |=> q.colpos == $past(ev_i.bit_pos))
        else $error("position not captured");
    // Line stays up until software reads the status
    irq_hold_a: assert property (
        (irq_o && !rd_stat) |=> irq_o)
        else $error("interrupt dropped without status read");
    // Mode bit follows the control register with one flop of lag
    auto_mode_a: assert property (
        1'b1 |=> regulator_o.auto_mode == $past(q.regctl[R_AUTO]))
        else $error("regulator mode decode wrong");
    // Read data only in the cycle after a read strobe
    rdata_idle_a: assert property (
        !req_i.rd |=> rdata_o == '0)
        else $error("read data outside read cycle");

    tx_phase_c: cover property ($rose(ev_i.tx_active) ##[1:50] $fell(ev_i.tx_active));
    rx_phase_c: cover property (ev_i.sof ##[1:50] $fell(ev_i.rx_active));
    read_clear_c: cover property (irq_o ##1 rd_stat ##1 !irq_o);
    collision_c: cover property (col_ev);
    // Recorded but silenced event, the masking scenario
    masked_c: cover property (ev6 != '0 && (ev6 & q.mask) == '0);
endmodule

/* File: include/rfid_irq_pkg.sv */
package rfid_irq_pkg;
    // Register offsets
    localparam logic [7:0] OFS_PROTO  = 8'h01;
    localparam logic [7:0] OFS_REGCTL = 8'h0B;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK   = 8'h0D;
    localparam logic [7:0] OFS_COLLO  = 8'h0E;
    // Reset values and the regulator control write mask
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h3E;
    localparam logic [7:0] RST_REGCTL = 8'h87;
    localparam logic [7:0] RST_PROTO  = 8'h00;
    localparam logic [7:0] REGCTL_WMASK = 8'hE7;
    // Status bit positions
    localparam int B_TX  = 7;
    localparam int B_SRX = 6;
    localparam int B_FIFO = 5;
    localparam int B_CRC = 4;
    localparam int B_PAR = 3;
    localparam int B_FRM = 2;
    localparam int B_COL = 1;
    localparam int B_NRSP = 0;
    // Protocol control fields
    localparam int P_NO_RX_CRC = 7;
    localparam int P_COLLISION_POS_LOW_MSB_SEL  = 6;
    localparam int P_NOT_TYPE_A = 0;
    // Regulator control fields
    localparam int R_AUTO = 7;
    // FIFO thresholds and collision edge limits
    localparam logic [3:0] FIFO_RX_HIGH = 4'h8;
    localparam logic [3:0] FIFO_TX_LOW  = 4'h4;
    localparam logic [3:0] COL_EDGES_6  = 4'h6;
    localparam logic [3:0] COL_EDGES_7  = 4'h7;
    // Headroom in millivolts and the codes that select it
    localparam logic [8:0] HEAD_250 = 9'h0FA;
    localparam logic [8:0] HEAD_350 = 9'h15E;
    localparam logic [8:0] HEAD_400 = 9'h190;
    localparam logic [1:0] VS_250 = 2'h3;
    localparam logic [1:0] VS_350 = 2'h2;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Events from the framing datapath
    typedef struct packed {
        logic       tx_active;
        logic       rx_active;
        logic       sof;
        logic [3:0] fifo_count;
        logic       crc_fail;
        logic       parity_fail;
        logic       framing_fail;
        logic       eof_fail;
        logic       bit_end;
        logic [3:0] bit_edges;
        logic [9:0] bit_pos;
        logic       noresp_timeout;
    } rf_event_t;

    // Regulator decode
    typedef struct packed {
        logic       auto_mode;
        logic [2:0] manual_set;
        logic [8:0] headroom_mv;
    } reg_sel_t;

    // Whole block state
    typedef struct packed {
        logic       en_meta;
        logic       en_sync;
        logic [7:0] status;
        logic [5:0] mask;
        logic [9:0] colpos;
        logic [7:0] regctl;
        logic [7:0] proto;
        logic       tx_d;
        logic       rx_d;
        logic       irq;
        logic       dec_en;
        logic [7:0] rdata;
        reg_sel_t   regsel;
    } state_t;
endpackage

/* File: bench/rf_event_model.sv */
`timescale 1ns/1ps
module rf_event_model
    import rfid_irq_pkg::*;
(
    // Clock
    input  wire logic clk_i,
    // Events toward the block
    output rf_event_t ev_o
);
    // Quiet datapath; idle fill level sits between both thresholds
    initial ev_o = '{fifo_count: 4'h6, default: '0};

    // Phase begins: level held, one start-of-frame pulse on receive
    task automatic start(input logic tx, input logic [3:0] lvl);
        @(posedge clk_i);
        ev_o.tx_active  <= tx;
        ev_o.rx_active  <= ~tx;
        ev_o.sof        <= ~tx;
        ev_o.fifo_count <= lvl;
        @(posedge clk_i);
        ev_o.sof <= 1'b0;
    endtask

    // Phase ends
    task automatic stop();
        @(posedge clk_i);
        ev_o.tx_active  <= 1'b0;
        ev_o.rx_active  <= 1'b0;
        ev_o.fifo_count <= 4'h6;
        @(posedge clk_i);
    endtask

    // One-cycle fault pulse; position inverted afterwards so late capture shows
    task automatic fault(input int k, input logic [3:0] e, input logic [9:0] pos);
        @(posedge clk_i);
        {ev_o.crc_fail, ev_o.parity_fail, ev_o.framing_fail, ev_o.eof_fail,
         ev_o.noresp_timeout, ev_o.bit_end} <= 6'(6'h20 >> k);
        ev_o.bit_edges <= e;
        ev_o.bit_pos   <= pos;
        @(posedge clk_i);
        {ev_o.crc_fail, ev_o.parity_fail, ev_o.framing_fail, ev_o.eof_fail,
         ev_o.noresp_timeout, ev_o.bit_end} <= 6'h00;
        ev_o.bit_pos   <= ~pos;
    endtask
endmodule

/* File: bench/rfid_reader_irq_status_logic_test.sv */
`timescale 1ns/1ps
module rfid_reader_irq_status_logic_test;
    import rfid_irq_pkg::*;
    logic        clk_i, sys_rst_i, enable_i;
    reg_req_t    req;
    rf_event_t   ev;
    logic [7:0]  rdata_o;
    logic        irq_o, decoder_enable_o;
    reg_sel_t    regulator_o;
    logic [31:0] seed;
    int          err_count, check_count, cycles;

    rf_event_model src (.clk_i(clk_i), .ev_o(ev));
    rfid_irq_status DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
        .req_i(req), .rdata_o(rdata_o), .ev_i(ev), .irq_o(irq_o),
        .decoder_enable_o(decoder_enable_o), .regulator_o(regulator_o));

    // Random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Status flag expected for each fault kind
    function automatic logic [7:0] flag_of(input int k);
        case (k)
            0: return 8'h01 << B_CRC;
            1: return 8'h01 << B_PAR;
            2, 3: return 8'h01 << B_FRM;
            4: return 8'h01 << B_NRSP;
            default: return 8'h01 << B_COL;
        endcase
    endfunction

    // Headroom per automatic code
    function automatic logic [8:0] head_of(input logic [1:0] v);
        return (v == 2'h3) ? 9'h0FA : (v == 2'h2) ? 9'h15E : 9'h190;
    endfunction

    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Register bus cycles; read data looked at only in the cycle after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        chk("rdata", {2'h0, e}, {2'h0, rdata_o});
    endtask
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Clock, 8 ns
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        logic [1:0] cd [3] = '{2'h3, 2'h2, 2'h0};
        logic [3:0] lv [4] = '{4'h4, 4'h3, 4'h8, 4'h9};
        logic [7:0] d;
        sys_rst_i = 1'b1;
        enable_i = 1'b1;
        req = '0;
        seed = 32'h4F23E7CA;
        err_count = 0;
        check_count = 0;
        cycles = 0;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(OFS_MASK, 8'h3E);
        rd(OFS_COLLO, 8'h00);
        wr(OFS_STATUS, 8'hFF);
        wr(8'h30, 8'hFF);
        rd(OFS_STATUS, 8'h00);
        rd(8'h30, 8'h00);
        // Transmit and receive phases at fill-level boundaries
        for (int i = 0; i < 4; i++) begin
            src.start(i < 2, lv[i]);
            if (i < 2) src.fault(0, 4'h0, 10'h000);
            settle();
            if (i < 2) chk("decoder", 10'h000, {9'h000, decoder_enable_o});
            if (i % 2 == 0) chk("irq_mid", 10'h000, {9'h000, irq_o});
            src.stop();
            settle();
            chk("irq_end", 10'h001, {9'h000, irq_o});
            rd(OFS_STATUS, {i < 2, i >= 2, i % 2 == 1, 5'h00});
            chk("irq_clr", 10'h000, {9'h000, irq_o});
        end
        // Each fault kind at a random position
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            src.fault(k, 4'h7, seed[9:0]);
            settle();
            chk("irq_err", {9'h000, k != 4}, {9'h000, irq_o});
            rd(OFS_STATUS, flag_of(k));
        end
        rd(OFS_MASK, {seed[9:8], 6'h3E});
        rd(OFS_MASK, 8'h3E);
        rd(OFS_COLLO, seed[7:0]);
        rd(OFS_COLLO, 8'h00);
        // Edge-count limits both ways
        src.fault(5, 4'h6, 10'h000);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_PROTO, 8'h40);
        src.fault(5, 4'h7, 10'h000);
        rd(OFS_STATUS, 8'h00);
        src.fault(5, 4'h8, 10'h000);
        rd(OFS_STATUS, 8'h02);
        // Protocol write clears; non-Type-A error positions
        src.fault(1, 4'h0, 10'h000);
        wr(OFS_PROTO, 8'h81);
        rd(OFS_STATUS, 8'h00);
        src.fault(0, 4'h0, 10'h000);
        rd(OFS_STATUS, 8'h00);
        seed = lfsr(seed);
        src.fault(2, 4'h0, seed[9:0]);
        rd(OFS_COLLO, seed[7:0]);
        rd(OFS_STATUS, 8'h04);
        // Masked events only record
        wr(OFS_PROTO, 8'h00);
        wr(OFS_MASK, 8'h01);
        src.fault(1, 4'h0, 10'h000);
        settle();
        chk("irq_masked", 10'h000, {9'h000, irq_o});
        src.fault(4, 4'h0, 10'h000);
        settle();
        chk("irq_noresp", 10'h001, {9'h000, irq_o});
        rd(OFS_STATUS, 8'h09);
        // Regulator codes, third voltage bit random
        for (int v = 0; v < 3; v++) begin
            seed = lfsr(seed);
            d = {1'b1, seed[4:0], cd[v]};
            wr(OFS_REGCTL, d);
            settle();
            chk("headroom", {1'b0, head_of(cd[v])}, {1'b0, regulator_o.headroom_mv});
            chk("auto", 10'h001, {9'h000, regulator_o.auto_mode});
            rd(OFS_REGCTL, d & REGCTL_WMASK);
        end
        wr(OFS_REGCTL, 8'h05);
        settle();
        chk("manual", 10'h005, {6'h00, regulator_o.auto_mode, regulator_o.manual_set});
        // Enable pin low restores defaults
        @(posedge clk_i);
        enable_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        enable_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(OFS_MASK, 8'h3E);
        rd(OFS_REGCTL, RST_REGCTL);
        end_of_test();
    end
endmodule
